// File: tb/host_irq_input.sv
// Host side of the interrupt wire: pull-up and interrupt input
`timescale 1ns/10ps
`default_nettype none
module host_irq_input
(
    input  wire irq_pin_out,
    input  wire irq_pin_oe_n,
    input  wire active_high,
    output wire irq_seen
);
    // Released wire floats to the pull-up level
    wire line = irq_pin_oe_n ? 1'b1 : irq_pin_out;
    assign irq_seen = active_high ? line : !line;
endmodule
`default_nettype wire

// File: tb/irq_output_holdoff_control_test.sv
// Self-checking bench of the interrupt pin stage
`timescale 1ns/10ps
`default_nettype none
module irq_output_holdoff_control_test;
    reg         clk = 0, sys_rst = 1, soft_rst = 0, reg_wr = 0, reg_rd = 0;
    reg         source_active = 0, power_event = 0, host_hi = 0;
    reg  [7:0]  reg_addr = 8'h00;
    reg  [31:0] reg_wdata = 32'h0, v;
    wire [31:0] reg_rdata;
    wire        irq_pin_out, irq_pin_oe_n, holdoff_active, irq_seen;
    integer     seed = 43, num_errors = 0, total_checks = 0, i, n;
    irq_output_holdoff_control uut (.clk(clk), .sys_rst(sys_rst), .soft_rst(soft_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .source_active(source_active), .power_event(power_event), .irq_pin_out(irq_pin_out),
        .irq_pin_oe_n(irq_pin_oe_n), .holdoff_active(holdoff_active));
    host_irq_input host (.irq_pin_out(irq_pin_out), .irq_pin_oe_n(irq_pin_oe_n), .active_high(host_hi),
        .irq_seen(irq_seen));
    initial
    begin
        forever #2 clk = ~clk;
    end
    // ---
    // Tasks
    // ---
    function [31:0] cfg_word(input [7:0] len, input en, input pol, input typ);
        cfg_word = {len, 15'h0, en, 3'h0, pol, 3'h0, typ};
    endfunction
    task check(input [31:0] seen, input [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task finish_test;
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 0;
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        @(posedge clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 0;
        #1 check(reg_rdata, exp);
        @(posedge clk);
    endtask
    task cfg(input [7:0] len, input rs, input en, input pol, input typ);
        wr(8'h54, cfg_word(len, en, pol, typ) | {17'h0, rs, 14'h0});
        host_hi = pol & typ;
    endtask
    task pin(input e);
        repeat (3) @(posedge clk);
        #1 check(irq_seen, e);
        @(posedge clk);
    endtask
    // Counts cycles while the interval runs; a stuck interval ends the run
    task count_hold;
        n = 0;
        #1;
        while (holdoff_active === 1'b1 && n < 6000)
        begin
            n = n + 1;
            @(posedge clk);
            #1;
        end
        if (n == 6000)
        begin
            num_errors = num_errors + 1;
            finish_test;
        end
        @(posedge clk);
    endtask
    // ---
    // Main sequence
    // ---
    initial
    begin
        repeat (4) @(posedge clk);
        sys_rst <= 0;
        rd(8'h54, 32'h0);
        check(irq_seen, 0);
        for (i = 0; i < 16; i = i + 1)
        begin
            v = $random(seed);
            if (v[7:0] == 8'h54)
                v[7:0] = 8'h58;
            wr(v[7:0], $random(seed));
            rd(v[7:0], 32'h0);
        end
        rd(8'h54, 32'h0);
        for (i = 0; i < 8; i = i + 1)
        begin
            cfg(0, 0, i[2], i[1], i[0]);
            source_active <= 1;
            pin(i[2]);
            rd(8'h54, cfg_word(0, i[2], i[1], i[0]) | 32'h1000);
            source_active <= 0;
            pin(0);
        end
        cfg(1, 0, 1, 1, 1);
        source_active <= 1;
        pin(1);
        source_active <= 0;
        pin(0);
        rd(8'h54, cfg_word(1, 1, 1, 1) | 32'h2000);
        source_active <= 1;
        pin(0);
        power_event <= 1;
        pin(1);
        power_event <= 0;
        pin(0);
        count_hold;
        pin(1);
        source_active <= 0;
        pin(0);
        source_active <= 1;
        pin(0);
        cfg(0, 0, 1, 1, 1);
        pin(1);
        rd(8'h54, cfg_word(0, 1, 1, 1) | 32'h1000);
        cfg(2, 1, 1, 1, 1);
        count_hold;
        check(n, 5000);
        pin(1);
        // Hold-off after service uses the new length: two steps of 2500
        // cycles, counted here from its second cycle on
        source_active <= 0;
        repeat (2) @(posedge clk);
        count_hold;
        check(n, 4999);
        source_active <= 1;
        pin(1);
        soft_rst <= 1;
        @(posedge clk);
        soft_rst <= 0;
        rd(8'h54, cfg_word(0, 0, 1, 1) | 32'h1000);
        pin(0);
        // Full reset in mid-run clears the fields a soft reset keeps
        sys_rst <= 1;
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        host_hi = 0;
        rd(8'h54, 32'h0000_1000);
        pin(0);
        finish_test;
    end
endmodule
`default_nettype wire

// File: tb/irq_pin_checker_assertions.sv
// Checker for the interrupt pin configuration and hold-off stage
`timescale 1ns/10ps
`default_nettype none
`include "irq_holdoff_regs.vh"
module irq_pin_checker
(
    input wire        clk,
    input wire        sys_rst,
    input wire        soft_rst,
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    input wire        source_active,
    input wire        power_event,
    input wire        irq_pin_out,
    input wire        irq_pin_oe_n,
    input wire        holdoff_active
);
    // ---
    // Shadow of the written fields
    // ---
    reg  [7:0]  len_reg;
    reg  [2:0]  mode_reg;
    reg  [20:0] cnt_reg;
    wire        cfg_wr = reg_wr && reg_addr == `CFG_OFFSET;
    wire        cfg_rd = reg_rd && reg_addr == `CFG_OFFSET;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            len_reg <= 8'h00;
            mode_reg <= 3'h0;
        end
        else if (soft_rst)
        begin
            len_reg <= 8'h00;
            mode_reg[2] <= 1'b0;
        end
        else if (cfg_wr)
        begin
            len_reg <= reg_wdata[31:24];
            mode_reg <= {reg_wdata[8], reg_wdata[4], reg_wdata[0]};
        end
    end
    // Restart write opens a fresh interval, so the count starts over
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            cnt_reg <= 21'h0;
        else if (cfg_wr && reg_wdata[14])
            cnt_reg <= 21'h0;
        else if (holdoff_active)
            cnt_reg <= cnt_reg + 21'h1;
        else
            cnt_reg <= 21'h0;
    end
    // Mode is {enable, polarity, type}
    function pin_ok(input [2:0] m, input act, input o, input oe_n);
        pin_ok = m[0] ? (!oe_n && o == (m[1] ? act : !act)) : (oe_n == !act && (oe_n || !o));
    endfunction
    // ---
    // Assertions
    // ---
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read slot");
    AST_UNMAPPED: assert property (reg_rd && reg_addr != `CFG_OFFSET |=> reg_rdata == 32'h0)
        else $error("unmapped read returned data");
    AST_RESERVED: assert property (cfg_rd |=> (reg_rdata & ~32'hff00_3111) == 32'h0)
        else $error("reserved or restart bit read as one");
    AST_FIELDS: assert property (cfg_rd |=> reg_rdata[31:24] == $past(len_reg)
        && {reg_rdata[8], reg_rdata[4], reg_rdata[0]} == $past(mode_reg))
        else $error("configuration field readback wrong");
    AST_MASTER: assert property (cfg_rd && $stable(source_active | power_event)
        |=> reg_rdata[12] == $past(source_active | power_event))
        else $error("master bit does not follow sources");
    AST_HOLD_STS: assert property (cfg_rd |=> reg_rdata[13] == $past(holdoff_active))
        else $error("hold status bit wrong");
    AST_PIN_OFF: assert property (!$past(mode_reg[2])
        |-> pin_ok($past(mode_reg), 1'b0, irq_pin_out, irq_pin_oe_n))
        else $error("disabled pin not at inactive level");
    AST_PIN_LEVEL: assert property ($past(mode_reg[2] && !cfg_wr && !soft_rst)
        |-> pin_ok($past(mode_reg), $past(source_active && !holdoff_active || power_event),
                   irq_pin_out, irq_pin_oe_n))
        else $error("pin level does not match request and hold state");
    AST_HOLD_LEN: assert property ($fell(holdoff_active) && !$past(reg_wr) && !$past(soft_rst)
        |-> ($past(cnt_reg) % `TICK_CYCLES) == `TICK_CYCLES - 1)
        else $error("hold-off length not a whole number of steps");
    COV_HOLD: cover property ($rose(holdoff_active));
    COV_BYPASS: cover property (holdoff_active && power_event);
    COV_READ: cover property (cfg_rd ##1 reg_rdata[13]);
endmodule
bind irq_output_holdoff_control irq_pin_checker chk (.clk(clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .source_active(source_active), .power_event(power_event), .irq_pin_out(irq_pin_out),
    .irq_pin_oe_n(irq_pin_oe_n), .holdoff_active(holdoff_active));
`default_nettype wire

// File: verilog/holdoff_tick_gen.v
// Divider that marks each 10 us step of a hold-off interval
`timescale 1ns/10ps
`default_nettype none

`include "irq_holdoff_regs.vh"

module holdoff_tick_gen
(
    input  wire clk,
    input  wire sys_rst,
    input  wire restart,
    input  wire run,
    output wire tick
);

    localparam integer           TICK_LAST_INT = `TICK_CYCLES - 1;
    localparam [`TICK_CNT_W-1:0] TICK_LAST     = TICK_LAST_INT[`TICK_CNT_W-1:0];

    reg [`TICK_CNT_W-1:0] cnt_reg;
    reg [`TICK_CNT_W-1:0] cnt_next;

    // ------------------------------------------------------------------------
    // Step counter
    // ------------------------------------------------------------------------
    // Restart aligns the step grid to the start of a fresh interval
    assign tick = run && !restart && (cnt_reg == TICK_LAST);

    always @*
    begin
        cnt_next = cnt_reg;
        if (restart || !run)
            cnt_next = {`TICK_CNT_W{1'b0}};
        else if (cnt_reg == TICK_LAST)
            cnt_next = {`TICK_CNT_W{1'b0}};
        else
            cnt_next = cnt_reg + {{(`TICK_CNT_W-1){1'b0}}, 1'b1};
    end

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            cnt_reg <= {`TICK_CNT_W{1'b0}};
        else
            cnt_reg <= cnt_next;
    end

endmodule

`default_nettype wire

// File: verilog/irq_holdoff_regs.vh
// Register map, field positions and timing constants of the interrupt pin stage
`ifndef IRQ_HOLDOFF_REGS_VH
`define IRQ_HOLDOFF_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CFG_OFFSET          8'h54

// ----------------------------------------------------------------------------
// Field positions of interrupt_pin_configuration
// ----------------------------------------------------------------------------
`define INTERVAL_MSB        31
`define INTERVAL_LSB        24
`define RESTART_BIT         14
`define HOLD_STS_BIT        13
`define MASTER_BIT          12
`define PIN_EN_BIT          8
`define POL_BIT             4
`define TYPE_BIT            0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CFG_RESET           32'h0000_0000
`define INTERVAL_RESET      8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define HOLDOFF_UNIT_NS     10000
`define CLK_PERIOD_NS       4
`define TICK_CYCLES         ((`HOLDOFF_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TICK_CNT_W          12

`endif

// File: verilog/irq_output_holdoff_control.v
// Interrupt pin configuration register, hold-off timer and pin driver stage
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`default_nettype none

`include "irq_holdoff_regs.vh"

// Overview of operation
// - Top byte holds hold-off interval, length is value times ten microseconds.
// - Writing zero interval stops hold-off, clears counter, releases pending interrupts.
// - A new non-zero interval applies to every later interrupt.
// - Power event interrupt bypasses hold-off and is never delayed.
// - Writing one to bit 14 restarts a fresh interval; bit self-clears.
// - Bit 13 reads one during hold-off; ordinary sources blocked from pin.
// - Read-only bit 12 shows the combined internal interrupt line.
// - Master bit ignores pin enable and hold-off setting.
// - Bit 8 zero keeps pin deasserted; one drives pin from line.
// - Pin enable affects only the pin, never internal status.
// - Bit 4 zero gives active-low pin; one gives active-high push-pull.
// - Bit 0 zero selects open-drain, one selects push-pull driver.
// - Open-drain always signals active low, polarity ignored.

module irq_output_holdoff_control
(
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        soft_rst,
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output wire [31:0] reg_rdata,
    input  wire        source_active,
    input  wire        power_event,
    output wire        irq_pin_out,
    output wire        irq_pin_oe_n,
    output wire        holdoff_active
);

    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam [0:0] ST_IDLE = 1'b0;
    localparam [0:0] ST_HOLD = 1'b1;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    function is_cfg;
        input [7:0] addr;
        begin
            is_cfg = (addr == `CFG_OFFSET);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    reg  [7:0]  holdoff_interval_reg;
    reg  [7:0]  holdoff_interval_next;
    reg         pin_enable_reg;
    reg         pin_enable_next;
    reg         pin_polarity_reg;
    reg         pin_polarity_next;
    reg         pin_push_pull_reg;
    reg         pin_push_pull_next;
    reg  [0:0]  state_reg;
    reg  [0:0]  state_next;
    reg  [7:0]  units_left_reg;
    reg  [7:0]  units_left_next;
    reg         delivered_reg;
    reg         delivered_next;
    reg         pin_out_reg;
    reg         pin_out_next;
    reg         pin_oe_n_reg;
    reg         pin_oe_n_next;
    reg  [31:0] rdata_reg;
    reg  [31:0] rdata_next;
    reg         hold_start;
    reg         line_active;
    reg         hold_out_reg;

    wire        cfg_wr;
    wire        cfg_rd;
    wire [7:0]  wr_interval;
    wire        wr_restart;
    wire        master_line;
    wire        source_path;
    wire        tick;
    wire        serviced;
    wire [7:0]  service_len;

    assign cfg_wr      = reg_wr && is_cfg(reg_addr);
    assign cfg_rd      = reg_rd && is_cfg(reg_addr);
    assign wr_interval = reg_wdata[`INTERVAL_MSB:`INTERVAL_LSB];
    assign wr_restart  = reg_wdata[`RESTART_BIT];

    // ------------------------------------------------------------------------
    // Internal interrupt line
    // ------------------------------------------------------------------------
    // Neither pin enable nor hold-off touches the master line
    assign master_line = source_active || power_event;

    // Ordinary sources are held back while a hold-off interval runs
    assign source_path = source_active && (state_reg == ST_IDLE);

    // ------------------------------------------------------------------------
    // Service detect
    // ------------------------------------------------------------------------
    // Power event never counts as service: it must not start a hold-off
    // that would then delay the ordinary sources behind it
    assign serviced    = delivered_reg && !source_active;

    // A value written in the same cycle already counts for this hold-off
    assign service_len = holdoff_interval_next;

    // ------------------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------------------
    // Polarity and driver type survive a soft reset so the pin never
    // glitches to the wrong level while software re-initialises the block
    always @*
    begin
        holdoff_interval_next = holdoff_interval_reg;
        pin_enable_next       = pin_enable_reg;
        pin_polarity_next     = pin_polarity_reg;
        pin_push_pull_next    = pin_push_pull_reg;
        if (soft_rst)
        begin
            holdoff_interval_next = `INTERVAL_RESET;
            pin_enable_next       = 1'b0;
        end
        else if (cfg_wr)
        begin
            holdoff_interval_next = wr_interval;
            pin_enable_next       = reg_wdata[`PIN_EN_BIT];
            pin_polarity_next     = reg_wdata[`POL_BIT];
            pin_push_pull_next    = reg_wdata[`TYPE_BIT];
        end
    end

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            holdoff_interval_reg <= `INTERVAL_RESET;
            pin_enable_reg       <= 1'b0;
            pin_polarity_reg     <= 1'b0;
            pin_push_pull_reg    <= 1'b0;
        end
        else
        begin
            holdoff_interval_reg <= holdoff_interval_next;
            pin_enable_reg       <= pin_enable_next;
            pin_polarity_reg     <= pin_polarity_next;
            pin_push_pull_reg    <= pin_push_pull_next;
        end
    end

    // ------------------------------------------------------------------------
    // Hold-off state machine
    // ------------------------------------------------------------------------
    // A zero interval written in the same cycle as a restart wins:
    // hold-off is then disabled and nothing is started
    always @*
    begin
        state_next      = state_reg;
        units_left_next = units_left_reg;
        hold_start      = 1'b0;
        if (soft_rst)
        begin
            state_next      = ST_IDLE;
            units_left_next = 8'h00;
        end
        else if (cfg_wr && (wr_interval == 8'h00))
        begin
            state_next      = ST_IDLE;
            units_left_next = 8'h00;
        end
        else if (cfg_wr && wr_restart)
        begin
            hold_start      = 1'b1;
            state_next      = ST_HOLD;
            units_left_next = wr_interval;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    // Service seen as the delivered request dropping
                    if (serviced && (service_len != 8'h00))
                    begin
                        hold_start      = 1'b1;
                        state_next      = ST_HOLD;
                        units_left_next = service_len;
                    end
                end
                ST_HOLD:
                begin
                    if (tick)
                    begin
                        // Last step ends the interval; pending requests reach the pin next cycle
                        if (units_left_reg <= 8'h01)
                        begin
                            state_next      = ST_IDLE;
                            units_left_next = 8'h00;
                        end
                        else
                            units_left_next = units_left_reg - 8'h01;
                    end
                end
                default:
                begin
                    state_next      = ST_IDLE;
                    units_left_next = 8'h00;
                end
            endcase
        end
    end

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg      <= ST_IDLE;
            units_left_reg <= 8'h00;
        end
        else
        begin
            state_reg      <= state_next;
            units_left_reg <= units_left_next;
        end
    end

    holdoff_tick_gen u_tick
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .restart (hold_start),
        .run     (state_reg == ST_HOLD),
        .tick    (tick)
    );

    // ------------------------------------------------------------------------
    // Hold status output
    // ------------------------------------------------------------------------
    // Own flop, loaded from the next state, so the status output changes
    // at the same edge as the state and never shows a decode glitch
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            hold_out_reg <= 1'b0;
        else
            hold_out_reg <= (state_next == ST_HOLD);
    end

    assign holdoff_active = hold_out_reg;

    // ------------------------------------------------------------------------
    // Delivered request and pin driver
    // ------------------------------------------------------------------------
    // Power event goes straight to the pin, not through the hold-off gate
    always @*
    begin
        line_active    = source_path || power_event;
        delivered_next = source_path;
        pin_out_next   = 1'b0;
        pin_oe_n_next  = 1'b1;
        if (!pin_enable_reg)
            line_active = 1'b0;
        if (!pin_push_pull_reg)
        begin
            // Open drain pulls low only; polarity is meaningless here
            pin_out_next  = 1'b0;
            pin_oe_n_next = !line_active;
        end
        else
        begin
            pin_oe_n_next = 1'b0;
            pin_out_next  = pin_polarity_reg ? line_active : !line_active;
        end
    end

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            delivered_reg <= 1'b0;
            pin_out_reg   <= 1'b0;
            pin_oe_n_reg  <= 1'b1;
        end
        else
        begin
            delivered_reg <= delivered_next;
            pin_out_reg   <= pin_out_next;
            pin_oe_n_reg  <= pin_oe_n_next;
        end
    end

    assign irq_pin_out  = pin_out_reg;
    assign irq_pin_oe_n = pin_oe_n_reg;

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    // Restart bit is write-only and always reads back zero
    // Reserved bits stay zero so software can write back what it read
    function [31:0] cfg_view;
        input [7:0] interval;
        input       hold;
        input       master;
        input       enable;
        input       polarity;
        input       push_pull;
        begin
            cfg_view = 32'h0000_0000;
            cfg_view[`INTERVAL_MSB:`INTERVAL_LSB] = interval;
            cfg_view[`RESTART_BIT]  = 1'b0;
            cfg_view[`HOLD_STS_BIT] = hold;
            cfg_view[`MASTER_BIT]   = master;
            cfg_view[`PIN_EN_BIT]   = enable;
            cfg_view[`POL_BIT]      = polarity;
            cfg_view[`TYPE_BIT]     = push_pull;
        end
    endfunction

    always @*
    begin
        rdata_next = 32'h0000_0000;
        if (cfg_rd)
            rdata_next = cfg_view(holdoff_interval_reg, (state_reg == ST_HOLD), master_line,
                                  pin_enable_reg, pin_polarity_reg, pin_push_pull_reg);
    end

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdata_reg <= `CFG_RESET;
        else
            rdata_reg <= rdata_next;
    end

    assign reg_rdata = rdata_reg;

endmodule

`default_nettype wire
